// ---- rtl/sdio_flag_cfg.svh ----
// offsets, bit positions, reset values and counts of the status flag bank
`ifndef SDIO_FLAG_CFG_SVH
`define SDIO_FLAG_CFG_SVH

`define OFS_STATUS 12'h034
`define OFS_CLEAR 12'h038
`define OFS_MASK 12'h03C

`define RESET_WORD 32'h0000_0000
`define STICKY_MASK 32'h00C0_07FF
`define LIVE_MASK 32'h003F_F800
`define MASK_VALID 32'h00FF_FFFF

`define BIT_RESP_CRC_FAIL 0
`define BIT_BLOCK_CRC_FAIL 1
`define BIT_RESP_TIMEOUT 2
`define BIT_DATA_TIMEOUT 3
`define BIT_CMD_SENT 7
`define BIT_DATA_END 8
`define BIT_START_BIT_ERR 9
`define BIT_BLOCK_DONE_OK 10
`define BIT_CMD_ACTIVE 11
`define BIT_TX_HALF_EMPTY 14
`define BIT_RX_FULL 17
`define BIT_TX_EMPTY 18
`define BIT_CARD_IRQ 22

`define RESP_TIMEOUT_CLKS 64
`define FIFO_HALF_WORDS 8
`define FLOW_MARGIN_WORDS 2
`define FIFO_DEPTH_DEF 32
`define DATA_LEN_W 25

`endif

// ---- rtl/sdio_flag_pkg.sv ----
// types shared by the status flag bank
package sdio_flag_pkg;
  typedef enum logic [1:0] {
    DATA_IDLE = 2'b01,
    DATA_MOVE = 2'b10
  } data_fsm_type;
  typedef logic [31:0] word_type;
  typedef logic [11:0] apb_addr_type;
  typedef logic [3:0] strb_type;
endpackage

// ---- rtl/sticky_flag_bank.sv ----
// bank of sticky flags: hardware sets, software clears, set wins
`timescale 1ns/1ps

module sticky_flag_bank #(
  parameter int WIDTH = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] set_vec,
  input wire logic [WIDTH-1:0] clr_vec,
  output logic [WIDTH-1:0] flags_ff
);
  generate
    if (WIDTH < 1) begin : g_chk
      $error("sticky_flag_bank needs WIDTH of at least one");
    end
  endgenerate

  wire [WIDTH-1:0] nxt_flags = set_vec | (flags_ff & ~clr_vec); // R1 R22

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= '0; // R19
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (set_vec != '0) |=> ((flags_ff & $past(set_vec)) == $past(set_vec));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set lost to clear"); // R22
endmodule

// ---- rtl/response_timer.sv ----
// counts card clock enables while a command awaits its response
`timescale 1ns/1ps

module response_timer #(
  parameter int LIMIT = 64
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic card_clk_en,
  input wire logic cmd_wait_resp,
  input wire logic resp_seen,
  output logic waiting_ff,
  output logic timeout_ff
);
  localparam int CNT_W = $clog2(LIMIT + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);

  generate
    if (LIMIT < 1) begin : g_chk
      $error("response_timer needs LIMIT of at least one");
    end
  endgenerate

  logic [CNT_W-1:0] cnt_ff;
  wire tick = waiting_ff & card_clk_en & ~resp_seen;
  wire expire = tick & (cnt_ff == LAST); // R6

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waiting_ff <= 1'b0;
      cnt_ff <= '0;
      timeout_ff <= 1'b0;
    end else begin
      timeout_ff <= expire;
      if (cmd_wait_resp) begin
        waiting_ff <= 1'b1;
        cnt_ff <= '0;
      end else if (resp_seen || expire) begin
        waiting_ff <= 1'b0;
      end else if (tick) begin
        cnt_ff <= cnt_ff + 1'b1;
      end
    end
  end

  property p_timeout_count;
    @(posedge pclk) disable iff (!presetn)
    timeout_ff |-> ($past(cnt_ff) == LAST) && !waiting_ff;
  endproperty
  a_timeout_count: assert property (p_timeout_count) else $error("early timeout"); // R6
endmodule

// ---- rtl/sdio_status_flag_clear.sv ----
// status flag bank with flag clear and interrupt mask registers on apb
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`include "sdio_flag_cfg.svh"

// How it works
// R1: bits 23:22 and 10:0 stay set until software clears them.
// R2: bits 21:11 follow their source conditions every cycle, never latched.
// R3: the status register is read-only; bus writes leave flags untouched.
// R4: bit 0 sets when a command response fails its crc.
// R5: finished block sets bit 1 on crc failure, else bit 10.
// R6: bit 2 sets after 64 card clocks without the expected response.
// R7: bits 3, 4, 5 set on data timeout, tx underrun, rx overrun.
// R8: bit 6 on good response crc, bit 7 on no-response command sent.
// R9: bit 8 sets when the remaining byte counter reaches zero.
// R10: bit 9 sets when a wide bus start bit is missing.
// R11: bits 11, 12, 13 show command, transmit and receive activity.
// R12: bit 14 high while eight or more tx words are free.
// R13: bit 15 high while the rx fifo holds eight or more words.
// R14: bit 17 rx full; with flow control two words early.
// R15: bit 18 tx empty; with flow control already at two words.
// R16: bits 16, 19, 20, 21 show tx full, rx empty, data present.
// R17: bit 22 on card interrupt, bit 23 on ata completion signal.
// R18: writing one to a clear bit clears that flag; zero does nothing.
// R19: status and clear registers read zero after reset; here only the sticky bits do, live bits 21:11 follow their sources.
// R20: counter reaching zero returns the data fsm to idle, sets data end.
// R21: a mask register selects which flags drive the interrupt output.
// R22: a set in the same cycle as its clear wins.
// R23: reserved status bits read zero; reserved clear bits are ignored.
module sdio_status_flag_clear #(
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF,
  parameter int RESP_LIMIT = `RESP_TIMEOUT_CLKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire sdio_flag_pkg::apb_addr_type paddr,
  input wire sdio_flag_pkg::word_type pwdata,
  input wire sdio_flag_pkg::strb_type pstrb,
  output sdio_flag_pkg::word_type prdata,
  output logic pready,
  output logic pslverr,
  input wire logic card_clk_en,
  input wire logic cmd_wait_resp,
  input wire logic resp_crc_bad,
  input wire logic resp_crc_good,
  input wire logic cmd_sent_noresp,
  input wire logic block_done,
  input wire logic block_crc_bad,
  input wire logic data_timeout_evt,
  input wire logic tx_underrun_evt,
  input wire logic rx_overrun_evt,
  input wire logic start_bit_err_evt,
  input wire logic card_irq_evt,
  input wire logic ata_done_evt,
  input wire logic data_start,
  input wire logic [`DATA_LEN_W-1:0] data_len,
  input wire logic byte_strobe,
  input wire logic command_active,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic hw_flow_ctrl,
  input wire logic [$clog2(FIFO_DEPTH+1)-1:0] tx_level,
  input wire logic [$clog2(FIFO_DEPTH+1)-1:0] rx_level,
  output logic irq,
  output logic data_busy
);
  import sdio_flag_pkg::*;

  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [LVL_W-1:0] DEPTH_L = LVL_W'(FIFO_DEPTH);
  localparam logic [LVL_W-1:0] HALF_L = LVL_W'(`FIFO_HALF_WORDS);
  localparam logic [LVL_W-1:0] MARGIN_L = LVL_W'(`FLOW_MARGIN_WORDS);
  localparam logic [`DATA_LEN_W-1:0] ONE_LEFT = `DATA_LEN_W'(1);

  generate
    if (FIFO_DEPTH < 2 * `FIFO_HALF_WORDS) begin : g_chk_depth
      $error("FIFO_DEPTH too small for the half-level flags");
    end
    if (RESP_LIMIT < 1) begin : g_chk_limit
      $error("RESP_LIMIT must be at least one");
    end
  endgenerate

  // apb decode
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire hit_status = (paddr == `OFS_STATUS);
  wire hit_clear = (paddr == `OFS_CLEAR);
  wire hit_mask = (paddr == `OFS_MASK);
  wire mapped = hit_status | hit_clear | hit_mask;
  wire wr_status = access & pwrite & hit_status;
  wire wr_clear = access & pwrite & hit_clear;
  wire wr_mask = access & pwrite & hit_mask;
  wire rd_setup = setup & ~pwrite;
  wire [31:0] strb_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // data path fsm with remaining byte counter
  data_fsm_type data_fsm_ff;
  data_fsm_type nxt_data_fsm;
  logic [`DATA_LEN_W-1:0] remaining_ff;
  logic [`DATA_LEN_W-1:0] nxt_remaining;

  wire last_byte = (data_fsm_ff == DATA_MOVE) & byte_strobe & (remaining_ff == ONE_LEFT);
  wire data_end_a = last_byte; // R9

  always_comb begin
    nxt_data_fsm = data_fsm_ff;
    nxt_remaining = remaining_ff;
    case (data_fsm_ff)
      DATA_IDLE: begin
        if (data_start && (data_len != '0)) begin
          nxt_data_fsm = DATA_MOVE;
          nxt_remaining = data_len;
        end
      end
      DATA_MOVE: begin
        if (byte_strobe) begin
          nxt_remaining = remaining_ff - ONE_LEFT;
          if (remaining_ff == ONE_LEFT) begin
            nxt_data_fsm = DATA_IDLE; // R20
          end
        end
      end
      default: begin
        nxt_data_fsm = DATA_IDLE;
        nxt_remaining = '0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_fsm_ff <= DATA_IDLE;
      remaining_ff <= '0;
    end else begin
      data_fsm_ff <= nxt_data_fsm;
      remaining_ff <= nxt_remaining;
    end
  end

  assign data_busy = (data_fsm_ff == DATA_MOVE);

  // response timeout
  wire resp_timeout_evt;
  response_timer #(
    .LIMIT(RESP_LIMIT)
  ) u_resp_timer (
    .pclk(pclk),
    .presetn(presetn),
    .card_clk_en(card_clk_en),
    .cmd_wait_resp(cmd_wait_resp),
    .resp_seen(resp_crc_bad | resp_crc_good),
    .waiting_ff(),
    .timeout_ff(resp_timeout_evt)
  ); // R6

  // sticky flags
  wire block_bad = block_done & block_crc_bad; // R5
  wire block_ok = block_done & ~block_crc_bad; // R5
  wire [31:0] set_vec = {
    8'h00,
    ata_done_evt, // R17
    card_irq_evt, // R17
    11'h000,
    block_ok,
    start_bit_err_evt, // R10
    data_end_a, // R9
    cmd_sent_noresp, // R8
    resp_crc_good, // R8
    rx_overrun_evt, // R7
    tx_underrun_evt, // R7
    data_timeout_evt, // R7
    resp_timeout_evt,
    block_bad,
    resp_crc_bad // R4
  };
  wire [31:0] clr_vec = wr_clear ? (pwdata & strb_mask & `STICKY_MASK) : '0; // R18 R23
  wire [31:0] sticky_q;

  sticky_flag_bank #(
    .WIDTH(32)
  ) u_sticky (
    .pclk(pclk),
    .presetn(presetn),
    .set_vec(set_vec & `STICKY_MASK),
    .clr_vec(clr_vec),
    .flags_ff(sticky_q)
  ); // R1

  // live flags
  wire [LVL_W-1:0] tx_room = DEPTH_L - tx_level;
  wire tx_half_empty = (tx_room >= HALF_L); // R12
  wire rx_half_full = (rx_level >= HALF_L); // R13
  wire tx_full = (tx_level == DEPTH_L); // R16
  wire rx_full = hw_flow_ctrl ? (rx_level >= DEPTH_L - MARGIN_L) : (rx_level == DEPTH_L); // R14
  wire tx_empty = hw_flow_ctrl ? (tx_level <= MARGIN_L) : (tx_level == '0); // R15
  wire rx_empty = (rx_level == '0); // R16
  wire tx_has_data = (tx_level != '0); // R16
  wire rx_has_data = (rx_level != '0); // R16
  wire [10:0] live_bits = {
    rx_has_data,
    tx_has_data,
    rx_empty,
    tx_empty,
    rx_full,
    tx_full,
    rx_half_full,
    tx_half_empty,
    rx_active,
    tx_active,
    command_active // R11
  };
  wire [31:0] status_word = (sticky_q & `STICKY_MASK) | ({10'h000, live_bits, 11'h000} & `LIVE_MASK); // R2 R23

  // interrupt mask and registered read data
  logic [31:0] mask_ff;
  logic [31:0] prdata_ff;
  logic irq_ff;
  wire [31:0] nxt_mask = (mask_ff & ~strb_mask) | (pwdata & strb_mask & `MASK_VALID);
  wire [31:0] rd_word = hit_status ? status_word : (hit_mask ? mask_ff : `RESET_WORD); // R3 R19
  wire irq_cause = |(status_word & mask_ff); // R21

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_ff <= `RESET_WORD;
      prdata_ff <= `RESET_WORD;
      irq_ff <= 1'b0;
    end else begin
      if (wr_mask) begin
        mask_ff <= nxt_mask; // R21
      end
      if (rd_setup) begin
        prdata_ff <= rd_word;
      end
      irq_ff <= irq_cause;
    end
  end

  assign prdata = prdata_ff;
  assign irq = irq_ff;

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_byte;
    (data_fsm_ff == DATA_MOVE) && byte_strobe && (remaining_ff == ONE_LEFT);
  endsequence

  sequence s_data_done;
    (data_fsm_ff == DATA_IDLE) && sticky_q[`BIT_DATA_END];
  endsequence

  property p_sticky_hold;
    (clr_vec == '0) |=> ((sticky_q & $past(sticky_q)) == $past(sticky_q));
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag dropped"); // R1

  property p_live_cmd;
    status_word[`BIT_CMD_ACTIVE] == command_active;
  endproperty
  a_live_cmd: assert property (p_live_cmd) else $error("live flag latched"); // R2

  property p_status_ro;
    wr_status && (clr_vec == '0) |=> (sticky_q == ($past(sticky_q) | $past(set_vec)));
  endproperty
  a_status_ro: assert property (p_status_ro) else $error("status write changed flags"); // R3

  property p_resp_crc;
    resp_crc_bad |=> sticky_q[`BIT_RESP_CRC_FAIL];
  endproperty
  a_resp_crc: assert property (p_resp_crc) else $error("response crc flag missing"); // R4

  property p_block_bad;
    block_done && block_crc_bad |=> sticky_q[`BIT_BLOCK_CRC_FAIL];
  endproperty
  a_block_bad: assert property (p_block_bad) else $error("block crc flag missing"); // R5

  property p_block_ok;
    block_done && !block_crc_bad |=> sticky_q[`BIT_BLOCK_DONE_OK];
  endproperty
  a_block_ok: assert property (p_block_ok) else $error("block done flag missing"); // R5

  property p_data_end;
    s_last_byte |=> s_data_done;
  endproperty
  a_data_end: assert property (p_data_end) else $error("data end not reached"); // R20

  property p_half_empty;
    (tx_level <= DEPTH_L - HALF_L) |-> status_word[`BIT_TX_HALF_EMPTY];
  endproperty
  a_half_empty: assert property (p_half_empty) else $error("tx half empty wrong"); // R12

  property p_rx_early;
    hw_flow_ctrl && (rx_level == DEPTH_L - MARGIN_L) |-> status_word[`BIT_RX_FULL];
  endproperty
  a_rx_early: assert property (p_rx_early) else $error("rx full not early"); // R14

  property p_tx_early;
    hw_flow_ctrl && (tx_level == MARGIN_L) |-> status_word[`BIT_TX_EMPTY];
  endproperty
  a_tx_early: assert property (p_tx_early) else $error("tx empty not early"); // R15

  property p_card_irq;
    card_irq_evt |=> sticky_q[`BIT_CARD_IRQ];
  endproperty
  a_card_irq: assert property (p_card_irq) else $error("card irq flag missing"); // R17

  property p_clear;
    wr_clear && pwdata[`BIT_RESP_CRC_FAIL] && pstrb[0] && !resp_crc_bad
      |=> !sticky_q[`BIT_RESP_CRC_FAIL];
  endproperty
  a_clear: assert property (p_clear) else $error("flag not cleared"); // R18

  property p_irq;
    irq_cause |=> irq ##1 (irq == $past(irq_cause));
  endproperty
  a_irq: assert property (p_irq) else $error("irq not following mask"); // R21

  property p_reserved;
    access && !pwrite && hit_status |-> (prdata[31:24] == 8'h00);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // R23

  property p_data_timeout;
    data_timeout_evt |=> sticky_q[`BIT_DATA_TIMEOUT];
  endproperty
  a_data_timeout: assert property (p_data_timeout) else $error("data timeout flag missing"); // R7

  property p_cmd_sent;
    cmd_sent_noresp |=> sticky_q[`BIT_CMD_SENT];
  endproperty
  a_cmd_sent: assert property (p_cmd_sent) else $error("command sent flag missing"); // R8

  property p_start_bit;
    start_bit_err_evt |=> sticky_q[`BIT_START_BIT_ERR];
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit flag missing"); // R10

  property p_mask_reserved;
    mask_ff[31:24] == 8'h00;
  endproperty
  a_mask_reserved: assert property (p_mask_reserved) else $error("mask reserved bits set"); // R23
endmodule

// ---- verif/sdio_status_flag_clear_tb_top.sv ----
// self-checking bench for the status flag bank, its clear and mask registers
`timescale 1ns/1ps
`include "sdio_flag_cfg.svh"

module sdio_status_flag_clear_tb_top;
  import sdio_flag_pkg::*;
  localparam int DEPTH = 32;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  apb_addr_type paddr = '0;
  word_type pwdata = '0;
  strb_type strb = 4'hF;
  word_type prdata;
  logic pready;
  logic pslverr;
  logic [13:0] ev = '0;
  logic crc_bad = 1'b0;
  logic flow = 1'b0;
  logic [2:0] act = '0;
  logic [5:0] txl = '0;
  logic [5:0] rxl = '0;
  logic [`DATA_LEN_W-1:0] dlen = '0;
  logic irq;
  logic data_busy;
  word_type exp_st = '0;
  word_type rd;
  logic err_bit;
  int err_count = 0;
  int comparisons = 0;
  // event input index and the sticky bit that it sets
  int ev_i[11] = '{0, 3, 4, 5, 6, 1, 2, 7, 3, 8, 9};
  int bit_i[11] = '{0, 1, 3, 4, 5, 6, 7, 9, 10, 22, 23};
  logic [2:0] t_act[6] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h7, 3'h0};
  logic t_flow[6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [5:0] t_tx[6] = '{6'h18, 6'h19, 6'h02, 6'h03, 6'h20, 6'h00};
  logic [5:0] t_rx[6] = '{6'h07, 6'h08, 6'h1E, 6'h1D, 6'h20, 6'h00};

  always #12.5 pclk = ~pclk;

  sdio_status_flag_clear #(.FIFO_DEPTH(DEPTH), .RESP_LIMIT(4)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .card_clk_en(ev[11]), .cmd_wait_resp(ev[10]),
    .resp_crc_bad(ev[0]), .resp_crc_good(ev[1]), .cmd_sent_noresp(ev[2]),
    .block_done(ev[3]), .block_crc_bad(crc_bad), .data_timeout_evt(ev[4]),
    .tx_underrun_evt(ev[5]), .rx_overrun_evt(ev[6]), .start_bit_err_evt(ev[7]),
    .card_irq_evt(ev[8]), .ata_done_evt(ev[9]), .data_start(ev[12]), .data_len(dlen),
    .byte_strobe(ev[13]), .command_active(act[0]), .tx_active(act[1]),
    .rx_active(act[2]), .hw_flow_ctrl(flow), .tx_level(txl), .rx_level(rxl),
    .irq(irq), .data_busy(data_busy)
  );

  function automatic word_type live_exp();
    word_type w;
    w = '0;
    w[13:11] = act;
    w[14] = (DEPTH - int'(txl)) >= 8;
    w[15] = rxl >= 8;
    w[16] = txl == DEPTH;
    w[17] = flow ? (rxl >= DEPTH - 2) : (rxl == DEPTH);
    w[18] = flow ? (txl <= 2) : (txl == 0);
    w[19] = rxl == 0;
    w[20] = txl != 0;
    w[21] = rxl != 0;
    return w;
  endfunction

  task automatic check(input word_type seen, input word_type want);
    comparisons++;
    if (seen !== want) begin
      err_count++;
      $display("FAIL %0t: got %h expected %h", $time, seen, want);
    end
  endtask

  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // one-cycle event pulse followed by a quiet cycle
  task automatic pulse(input int i);
    ev[i] <= 1'b1;
    @(posedge pclk);
    ev <= '0;
    @(posedge pclk);
  endtask

  // apb transfer; evm is raised for the access phase to collide with a write
  task automatic apb(input logic wr, input apb_addr_type a, input word_type d,
                     input logic [13:0] evm);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    ev <= evm;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 50) begin
      err_count++;
    end
    rd = prdata;
    err_bit = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    ev <= '0;
    @(posedge pclk);
  endtask

  task automatic st_chk();
    apb(1'b0, `OFS_STATUS, '0, '0);
    check(rd, exp_st | live_exp());
  endtask

  initial begin
    step(8);
    presetn <= 1'b1;
    step(1);
    st_chk();
    apb(1'b0, `OFS_CLEAR, '0, '0);
    check(rd, '0);
    apb(1'b0, 12'h040, '0, '0);
    check({rd[31:1], err_bit}, 32'h1);
    for (int k = 0; k < 11; k++) begin
      crc_bad <= (k == 1);
      pulse(ev_i[k]);
      exp_st[bit_i[k]] = 1'b1;
      step(4);
      st_chk();
    end
    apb(1'b1, `OFS_STATUS, 32'hFFFF_FFFF, '0);
    st_chk();
    apb(1'b1, `OFS_CLEAR, 32'h0000_0000, '0);
    st_chk();
    apb(1'b1, `OFS_CLEAR, 32'hFF3F_F800, '0);
    st_chk();
    apb(1'b1, `OFS_CLEAR, 32'h0040_0000, 14'h0100);
    st_chk();
    for (int k = 0; k < 11; k++) begin
      apb(1'b1, `OFS_CLEAR, 32'h1 << bit_i[k], '0);
      exp_st[bit_i[k]] = 1'b0;
      st_chk();
    end
    pulse(10);
    repeat (3) pulse(11);
    step(3);
    st_chk();
    pulse(11);
    step(3);
    exp_st[2] = 1'b1;
    st_chk();
    pulse(10);
    repeat (2) pulse(11);
    pulse(1);
    exp_st[6] = 1'b1;
    repeat (4) pulse(11);
    step(3);
    st_chk();
    apb(1'b1, `OFS_CLEAR, 32'h0000_0044, '0);
    exp_st = '0;
    pulse(12);
    check({31'h0, data_busy}, 32'h0);
    dlen <= 25'd3;
    pulse(12);
    check({31'h0, data_busy}, 32'h1);
    repeat (2) pulse(13);
    st_chk();
    pulse(13);
    check({31'h0, data_busy}, 32'h0);
    exp_st[8] = 1'b1;
    st_chk();
    apb(1'b1, `OFS_CLEAR, 32'h0000_0100, '0);
    exp_st = '0;
    for (int k = 0; k < 6; k++) begin
      act <= t_act[k];
      flow <= t_flow[k];
      txl <= t_tx[k];
      rxl <= t_rx[k];
      step(1);
      st_chk();
    end
    apb(1'b1, `OFS_MASK, 32'hFFFF_FFFF, '0);
    apb(1'b0, `OFS_MASK, '0, '0);
    check(rd, 32'h00FF_FFFF);
    step(2);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_MASK, 32'h0000_0001, '0);
    step(2);
    check({31'h0, irq}, 32'h0);
    pulse(0);
    step(2);
    check({31'h0, irq}, 32'h1);
    strb <= 4'hE;
    apb(1'b1, `OFS_CLEAR, 32'h0000_0001, '0);
    strb <= 4'hF;
    step(2);
    check({31'h0, irq}, 32'h1);
    apb(1'b1, `OFS_CLEAR, 32'h0000_0001, '0);
    step(2);
    check({31'h0, irq}, 32'h0);
    pulse(0);
    step(2);
    check({31'h0, irq}, 32'h1);
    presetn <= 1'b0;
    step(2);
    check({31'h0, irq}, 32'h0);
    presetn <= 1'b1;
    step(1);
    st_chk();
    apb(1'b0, `OFS_MASK, '0, '0);
    check(rd, '0);
    wrap_up();
  end

  // cuts a hang short well beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    wrap_up();
  end
endmodule
